// file: pkg/gnss_capture_pkg.sv
// Constants, types and state layout for the satellite sample capture block.
// Assumes a single 10 MHz system clock and an AXI4-Lite register master.
package gnss_capture_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CFG_OFS       = 12'h024;
  localparam logic [ADDR_W-1:0] START_OFS     = 12'h028;
  localparam logic [ADDR_W-1:0] TOTAL_OFS     = 12'h02C;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 12'h030;
  localparam logic [ADDR_W-1:0] COUNTDOWN_OFS = 12'h034;

  // Configuration fields
  localparam int unsigned CFG_ENABLE_BIT = 0;
  localparam int unsigned CFG_FMT_LSB    = 1;
  localparam int unsigned CFG_WIDTH_BIT  = 3;
  localparam int unsigned CFG_INVERT_BIT = 4;
  localparam int unsigned CFG_TRACK_BIT  = 5;
  localparam int unsigned CFG_W          = 6;

  // Status fields
  localparam int unsigned STAT_TRACK_BIT = 0;
  localparam int unsigned STAT_OVF_BIT   = 1;

  // Reset values
  localparam logic [CFG_W-1:0]  CFG_RST   = 6'h00;
  localparam logic [DATA_W-1:0] START_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] TOTAL_RST = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Slot widths and samples per word for each packing
  localparam logic [3:0] SLOT_UNPACKED = 4'h8;
  localparam logic [5:0] SPW_UNPACKED  = 6'h04;
  localparam logic [3:0] SLOT_PACKED   = 4'h4;
  localparam logic [5:0] SPW_PACKED    = 6'h08;
  localparam logic [3:0] SLOT_SUPER_1  = 4'h1;
  localparam logic [5:0] SPW_SUPER_1   = 6'h20;
  localparam logic [3:0] SLOT_SUPER_3  = 4'h3;
  localparam logic [5:0] SPW_SUPER_3   = 6'h0A;

  // Word buffer geometry
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned BUF_W     = DATA_W;
  localparam int unsigned PTR_W     = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int unsigned CNT_W     = $clog2(BUF_DEPTH + 1);

  typedef enum logic [1:0] {
    FMT_UNPACKED = 2'b00,
    FMT_PACKED   = 2'b01,
    FMT_SUPER    = 2'b10,
    FMT_RSVD     = 2'b11
  } fmt_t;

  typedef enum logic [1:0] {
    PH_OFF   = 2'b00,
    PH_STORE = 2'b01,
    PH_COUNT = 2'b10
  } phase_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              valid;
  } word_t;

  typedef struct packed {
    logic                            clk_meta;
    logic                            clk_sync;
    logic                            clk_prev;
    logic [2:0]                      data_meta;
    logic [2:0]                      data_sync;
    phase_t                          phase;
    logic [CFG_W-1:0]                cfg;
    logic [DATA_W-1:0]               start;
    logic [DATA_W-1:0]               countdown;
    logic [DATA_W-1:0]               total;
    logic                            ovf;
    logic [DATA_W-1:0]               acc;
    logic [5:0]                      pos;
    logic [5:0]                      fill;
    logic [BUF_DEPTH-1:0][BUF_W-1:0] buf_data;
    logic [PTR_W-1:0]                wr_ptr;
    logic [PTR_W-1:0]                rd_ptr;
    logic [CNT_W-1:0]                buf_cnt;
    logic                            aw_got;
    logic [ADDR_W-1:0]               aw_addr;
    logic                            w_got;
    logic [DATA_W-1:0]               w_data;
    logic [3:0]                      w_strb;
    logic                            bvalid;
    logic [1:0]                      bresp;
    logic                            rvalid;
    logic [DATA_W-1:0]               rdata;
    logic [1:0]                      rresp;
  } cap_state_t;

  localparam cap_state_t ST_RST = '0;

endpackage

// file: rtl/gnss_sample_capture.sv
// Satellite sample capture: serial samples into the shared receive FIFO.
// Assumes the sample clock is far slower than mclk and the FIFO is on mclk.
//
// What this block does
// - Capture owns receive FIFO; serial path blocked
// - Config bit 5: store all, or count
// - Config bit 4 inverts the sample clock
// - Config bit 3: one or three bits
// - Writable count-down start sets handover point
// - Store until count-down zero, then count
// - Track cleared: store again, reload count-down
// - Read-only total of samples while tracking
// - Total cleared when tracking starts at zero
// - Total holds after tracking request clears
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

module gnss_sample_capture
  import gnss_capture_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Sample source pins
  input  wire logic              gnss_clk,
  input  wire logic [2:0]        gnss_data,
  // Serial peripheral receive words
  input  wire word_t             spi_rx,
  output logic                   spi_rx_ready,
  // Receive FIFO write side
  output word_t                  fifo_push,
  input  wire logic              fifo_ready
);

  cap_state_t st_ff;
  cap_state_t nxt_st;

  logic              enable;
  logic              track;
  logic              width3;
  fmt_t              fmt;
  logic              sel_clk;
  logic              clk_edge;
  logic [2:0]        sval;
  logic [3:0]        slot;
  logic [5:0]        spw;
  logic              go_count;
  logic              go_store;
  logic              storing;
  logic              counting;
  logic              store_smp;
  logic              count_smp;
  logic              word_done;
  logic              buf_full;
  logic              push;
  logic              lost;
  logic              pop;
  logic [DATA_W-1:0] acc_new;
  logic [DATA_W-1:0] cd_base;
  logic              aw_hs;
  logic              w_hs;
  logic              ar_hs;
  logic              wr_go;
  logic [DATA_W-1:0] wr_merged;
  logic [DATA_W-1:0] cfg_merged;
  logic [DATA_W-1:0] rd_val;
  logic              rd_hit;

  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old,
                                                    input logic [DATA_W-1:0] wd,
                                                    input logic [3:0]        strb);
    logic [DATA_W-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign enable = st_ff.cfg[CFG_ENABLE_BIT];
  assign track  = st_ff.cfg[CFG_TRACK_BIT];
  assign width3 = st_ff.cfg[CFG_WIDTH_BIT];
  assign fmt    = fmt_t'(st_ff.cfg[CFG_FMT_LSB +: 2]);

  // Edge of the synchronised, optionally inverted sample clock
  assign sel_clk  = st_ff.clk_sync ^ st_ff.cfg[CFG_INVERT_BIT];
  assign clk_edge = sel_clk & ~st_ff.clk_prev;
  assign sval     = width3 ? st_ff.data_sync : {2'h0, st_ff.data_sync[0]};

  always_comb begin
    case (fmt)
      FMT_PACKED: begin
        slot = SLOT_PACKED;
        spw  = SPW_PACKED;
      end
      FMT_SUPER: begin
        slot = width3 ? SLOT_SUPER_3 : SLOT_SUPER_1;
        spw  = width3 ? SPW_SUPER_3 : SPW_SUPER_1;
      end
      default: begin
        slot = SLOT_UNPACKED;
        spw  = SPW_UNPACKED;
      end
    endcase
  end

  // Phase decisions
  assign go_count  = enable & (st_ff.phase == PH_STORE) & track
                     & (st_ff.countdown == '0);
  assign go_store  = enable & (st_ff.phase == PH_COUNT) & ~track;
  assign storing   = enable & (((st_ff.phase == PH_STORE) & ~go_count) | go_store);
  assign counting  = enable & (((st_ff.phase == PH_COUNT) & ~go_store) | go_count);
  assign store_smp = storing & clk_edge;
  assign count_smp = counting & clk_edge;
  assign cd_base   = (go_store || st_ff.phase == PH_OFF) ? st_ff.start : st_ff.countdown;

  // Word assembly and the two-entry buffer
  assign acc_new   = st_ff.acc | (DATA_W'(sval) << st_ff.pos);
  assign word_done = store_smp & (st_ff.fill == spw - 6'h01);
  assign buf_full  = (st_ff.buf_cnt == CNT_W'(BUF_DEPTH));
  assign push      = word_done & ~buf_full;
  assign lost      = word_done & buf_full;
  assign pop       = enable & fifo_ready & (st_ff.buf_cnt != '0);

  // FIFO ownership
  assign spi_rx_ready    = ~enable & fifo_ready;
  assign fifo_push.valid = enable ? (st_ff.buf_cnt != '0) : spi_rx.valid;
  assign fifo_push.data  = enable ? st_ff.buf_data[st_ff.rd_ptr] : spi_rx.data;

  // Register slave
  assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready  = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_arready = ~st_ff.rvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;
  assign aw_hs         = s_axi_awvalid & s_axi_awready;
  assign w_hs          = s_axi_wvalid & s_axi_wready;
  assign ar_hs         = s_axi_arvalid & s_axi_arready;
  assign wr_go         = st_ff.aw_got & st_ff.w_got & ~st_ff.bvalid;
  assign wr_merged     = merge_bytes(st_ff.start, st_ff.w_data, st_ff.w_strb);
  assign cfg_merged    = merge_bytes({{(DATA_W-CFG_W){1'b0}}, st_ff.cfg},
                                     st_ff.w_data, st_ff.w_strb);

  always_comb begin
    rd_hit = 1'b1;
    case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
      CFG_OFS:       rd_val = {{(DATA_W-CFG_W){1'b0}}, st_ff.cfg};
      START_OFS:     rd_val = st_ff.start;
      TOTAL_OFS:     rd_val = st_ff.total;
      STATUS_OFS:    rd_val = {{(DATA_W-2){1'b0}}, st_ff.ovf, st_ff.phase == PH_COUNT};
      COUNTDOWN_OFS: rd_val = st_ff.countdown;
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // Two-flop synchronisers
    nxt_st.clk_meta  = gnss_clk;
    nxt_st.clk_sync  = st_ff.clk_meta;
    nxt_st.clk_prev  = sel_clk;
    nxt_st.data_meta = gnss_data;
    nxt_st.data_sync = st_ff.data_meta;

    // Write path: address and data in either order
    if (aw_hs) begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = {s_axi_awaddr[ADDR_W-1:2], 2'h0};
    end
    if (w_hs) begin
      nxt_st.w_got  = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_go) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = RESP_OKAY;
      case (st_ff.aw_addr)
        CFG_OFS: begin
          nxt_st.cfg = cfg_merged[CFG_W-1:0];
        end
        START_OFS:     nxt_st.start = wr_merged;
        STATUS_OFS: begin
          if (st_ff.w_strb[0] && st_ff.w_data[STAT_OVF_BIT]) begin
            nxt_st.ovf = 1'b0;
          end
        end
        TOTAL_OFS:     nxt_st.bresp = RESP_OKAY;
        COUNTDOWN_OFS: nxt_st.bresp = RESP_OKAY;
        default:       nxt_st.bresp = RESP_SLVERR;
      endcase
    end

    // Read path
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // Phase
    if (!enable) begin
      nxt_st.phase = PH_OFF;
    end else begin
      case (st_ff.phase)
        PH_OFF:   nxt_st.phase = PH_STORE;
        PH_STORE: nxt_st.phase = go_count ? PH_COUNT : PH_STORE;
        PH_COUNT: nxt_st.phase = go_store ? PH_STORE : PH_COUNT;
        default:  nxt_st.phase = PH_OFF;
      endcase
    end

    // Count-down runs while storing and stops at zero
    if (enable) begin
      nxt_st.countdown = cd_base;
      if (store_smp && cd_base != '0) begin
        nxt_st.countdown = cd_base - 32'h0000_0001;
      end
    end

    // Tracked total restarts at the handover, counts each sample while counting, holds otherwise
    if (go_count) begin
      nxt_st.total = count_smp ? 32'h0000_0001 : 32'h0000_0000;
    end else if (count_smp) begin
      nxt_st.total = st_ff.total + 32'h0000_0001;
    end

    // Assembly, low bit positions first
    if (store_smp) begin
      if (word_done) begin
        nxt_st.acc  = '0;
        nxt_st.pos  = '0;
        nxt_st.fill = '0;
      end else begin
        nxt_st.acc  = acc_new;
        nxt_st.pos  = st_ff.pos + {2'h0, slot};
        nxt_st.fill = st_ff.fill + 6'h01;
      end
    end
    // Full word with nowhere to go: flag it, set wins over clear
    if (lost) begin
      nxt_st.ovf = 1'b1;
    end

    if (push) begin
      nxt_st.buf_data[st_ff.wr_ptr] = acc_new;
      nxt_st.wr_ptr = (st_ff.wr_ptr == PTR_W'(BUF_DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == PTR_W'(BUF_DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.buf_cnt = st_ff.buf_cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_st.buf_cnt = st_ff.buf_cnt - 1'b1;
    end

    // Capture off: drop partial word and buffered words
    if (!enable) begin
      nxt_st.acc     = '0;
      nxt_st.pos     = '0;
      nxt_st.fill    = '0;
      nxt_st.wr_ptr  = '0;
      nxt_st.rd_ptr  = '0;
      nxt_st.buf_cnt = '0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  spi_block_a: assert property (enable |-> !spi_rx_ready && fifo_push.valid == (st_ff.buf_cnt != '0))
    else $error("serial path reached FIFO during capture");
  track_count_a: assert property (count_smp && !go_count |=> st_ff.total == $past(st_ff.total) + 32'h0000_0001)
    else $error("tracked total did not advance");
  invert_edge_a: assert property ((st_ff.cfg[CFG_INVERT_BIT] && $stable(st_ff.cfg[CFG_INVERT_BIT])
                                   && $fell(st_ff.clk_sync)) |-> clk_edge)
    else $error("inverted clock edge missed");
  narrow_sample_a: assert property (store_smp && !width3 |-> sval[2:1] == 2'h0)
    else $error("one-bit sample carries upper bits");
  word_length_a: assert property (push |-> st_ff.fill == spw - 6'h01)
    else $error("word pushed at wrong fill");
  countdown_step_a: assert property (store_smp && st_ff.phase == PH_STORE && st_ff.countdown != '0
                                     |=> st_ff.countdown == $past(st_ff.countdown) - 32'h0000_0001)
    else $error("count-down did not step");
  hold_store_a: assert property (enable && st_ff.phase == PH_STORE && st_ff.countdown != '0
                                 |=> st_ff.phase == PH_STORE)
    else $error("left storing before count-down expired");
  reload_a: assert property (go_store |=> st_ff.phase == PH_STORE
                             && (st_ff.countdown == $past(st_ff.start)
                                 || st_ff.countdown == $past(st_ff.start) - 32'h0000_0001))
    else $error("count-down not reloaded on return to storing");
  total_clear_a: assert property (go_count |=> st_ff.total <= 32'h0000_0001)
    else $error("tracked total not cleared at handover");
  total_hold_a: assert property (!counting |=> $stable(st_ff.total))
    else $error("tracked total moved outside tracking");
  off_empty_a: assert property (!enable |=> st_ff.buf_cnt == '0 && st_ff.phase == PH_OFF)
    else $error("capture off but words kept");
  fill_edge_a: assert property (enable && $past(enable) && $changed(st_ff.fill) |-> $past(clk_edge))
    else $error("assembly moved without a sample edge");
  bresp_hold_a: assert property (st_ff.bvalid && !s_axi_bready |=> st_ff.bvalid && $stable(st_ff.bresp))
    else $error("write response dropped early");

  word_push_c: cover property (push ##[1:20] pop);
  handover_c: cover property (go_count ##[1:200] go_store);
  overflow_c: cover property (lost);
  full_stall_c: cover property (buf_full && !fifo_ready [*3]);

endmodule

// file: dv/gnss_source_model.sv
// Behavioural satellite sample source: one sample per 800 ns period.
// Assumes the bench calls play and rest from one process, one at a time.
`timescale 1ns/10ps

module gnss_source_model (
  // Sample pins
  output logic       gnss_clk,
  output logic [2:0] gnss_data
);
  initial begin
    gnss_clk  = 1'b0;
    gnss_data = 3'h0;
  end

  // Active edge sees v, the other edge its inverse
  task automatic play(input logic [2:0] v, input logic inv);
    gnss_data = inv ? ~v : v;
    #200 gnss_clk = 1'b1;
    #200 gnss_data = inv ? v : ~v;
    #200 gnss_clk = 1'b0;
    #200;
  endtask

  // Clock stands low between frames, data lines no longer hold
  task automatic rest();
    #13 gnss_data = ~gnss_data;
    #400;
  endtask
endmodule

// file: dv/gnss_sample_capture_tb.sv
// Bench for the satellite sample capture block: registers, packing, tracking.
// Assumes the source model sits on the sample pins and a FIFO sink on the push side.
`timescale 1ns/10ps

module gnss_sample_capture_tb;
  import gnss_capture_pkg::*;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_awready;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_wvalid = 1'b0;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready = 1'b0;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_arready;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready = 1'b0;
  logic              s_axi_wready;
  logic              gnss_clk;
  logic [2:0]        gnss_data;
  word_t             spi_rx = '0;
  logic              spi_rx_ready;
  word_t             fifo_push;
  logic              fifo_ready = 1'b1;
  logic [31:0]       word_q[$];
  logic [33:0]       rd_q[$];
  logic [1:0]        b_q[$];
  int                err_count = 0;
  int                total_checks = 0;
  int                seed = 32'h5570;
  int                rdy_mode = 2;
  int                slot;
  int                spw;
  int                k;
  logic [31:0]       acc;
  logic [2:0]        msk;

  gnss_sample_capture i_gnss_sample_capture (
    .mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gnss_clk, .gnss_data, .spi_rx,
    .spi_rx_ready, .fifo_push, .fifo_ready
  );

  gnss_source_model i_gnss_source_model (.gnss_clk, .gnss_data);

  always #50 mclk = ~mclk;

  // Sink stalls at random, stands still, or always accepts
  always @(posedge mclk) fifo_ready <= (rdy_mode == 2) || (rdy_mode == 0 && 1'($random(seed)));

  task automatic chk(input string name, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  // Oldest note against each result as it is taken
  always @(negedge mclk) if (!rst) begin
    if (fifo_push.valid === 1'b1 && fifo_ready)
      chk("fifo_word", word_q.size() ? word_q.pop_front() : 'x, fifo_push.data);
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk("rdata", rd_q.size() ? rd_q.pop_front() : 'x, {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      chk("bresp", b_q.size() ? b_q.pop_front() : 'x, s_axi_bresp);
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw;
    logic w;
    logic b;
    b_q.push_back(r);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge mclk);
      aw = s_axi_awvalid && s_axi_awready;
      w  = s_axi_wvalid && s_axi_wready;
      b  = s_axi_bvalid && s_axi_bready;
      @(posedge mclk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    logic ar;
    logic r;
    rd_q.push_back(e);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge mclk);
      ar = s_axi_arvalid && s_axi_arready;
      r  = s_axi_rvalid && s_axi_rready;
      @(posedge mclk);
      if (ar)
        s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
  endtask

  // Writes config and restarts the word assembly model
  task automatic cfg(input logic [5:0] c);
    // Let noted words leave before a reconfiguration can drop them
    while (word_q.size() != 0) @(negedge mclk);
    msk  = c[3] ? 3'h7 : 3'h1;
    slot = c[2:1] == 2'b01 ? 4 : c[2:1] == 2'b10 ? (c[3] ? 3 : 1) : 8;
    spw  = c[2:1] == 2'b01 ? 8 : c[2:1] == 2'b10 ? (c[3] ? 10 : 32) : 4;
    acc  = '0;
    k    = 0;
    wr(CFG_OFS, {26'h0, c}, RESP_OKAY);
  endtask

  // Notes each finished word before its last sample is played
  task automatic feed(input int n, input logic inv, input logic st);
    logic [2:0] v;
    #37;
    for (int i = 0; i < n; i++) begin
      v = 3'($random(seed));
      if (st) begin
        acc = acc | (32'(v & msk) << (k * slot));
        k++;
        if (k == spw) begin
          word_q.push_back(acc);
          acc = '0;
          k   = 0;
        end
      end
      i_gnss_source_model.play(v, inv);
    end
    i_gnss_source_model.rest();
  endtask

  task automatic spi(input logic on);
    logic [31:0] d;
    d = $random(seed);
    if (!on)
      word_q.push_back(d);
    @(posedge mclk);
    spi_rx <= '{data: d, valid: 1'b1};
    @(negedge mclk);
    chk("spi_rx_ready", !on, spi_rx_ready);
    @(posedge mclk);
    spi_rx <= '{data: ~d, valid: 1'b0};
  endtask

  task automatic report_and_stop();
    if (word_q.size() != 0 || rd_q.size() != 0 || b_q.size() != 0) begin
      err_count++;
      $display("Error pending_notes expected 0 seen %0d", word_q.size() + rd_q.size() + b_q.size());
    end
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    #1_000_000;
    err_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rd(CFG_OFS, 34'h0);
    rd(START_OFS, 34'h0);
    rd(TOTAL_OFS, 34'h0);
    wr(TOTAL_OFS, $random(seed), RESP_OKAY);
    rd(TOTAL_OFS, 34'h0);
    wr(12'h100, 32'h5, RESP_SLVERR);
    rd(12'h100, {RESP_SLVERR, 32'h0});
    wr(CFG_OFS, 32'hFFFF_FFC0, RESP_OKAY);
    rd(CFG_OFS, 34'h0);
    wr(START_OFS, 32'hA5C3_0F96, RESP_OKAY);
    rd(START_OFS, 34'hA5C3_0F96);
    spi(1'b0);
    cfg(6'h01);
    spi(1'b1);
    rdy_mode = 0;
    for (int f = 0; f < 8; f++) begin
      cfg({2'b00, f[2], f[1:0], 1'b1});
      feed(spw, 1'b0, 1'b1);
      cfg(6'h00);
    end
    cfg(6'h10);
    cfg(6'h11);
    feed(8, 1'b1, 1'b1);
    cfg(6'h00);
    rdy_mode = 1;
    cfg(6'h01);
    feed(8, 1'b0, 1'b1);
    feed(4, 1'b0, 1'b0);
    rd(STATUS_OFS, 34'h2);
    rdy_mode = 0;
    wr(STATUS_OFS, 32'h2, RESP_OKAY);
    rd(STATUS_OFS, 34'h0);
    cfg(6'h00);
    wr(START_OFS, 32'h8, RESP_OKAY);
    cfg(6'h01);
    cfg(6'h21);
    feed(8, 1'b0, 1'b1);
    feed(4, 1'b0, 1'b0);
    rd(STATUS_OFS, 34'h1);
    rd(TOTAL_OFS, 34'h4);
    cfg(6'h01);
    rd(COUNTDOWN_OFS, 34'h8);
    feed(4, 1'b0, 1'b1);
    rd(COUNTDOWN_OFS, 34'h4);
    rd(TOTAL_OFS, 34'h4);
    cfg(6'h21);
    feed(4, 1'b0, 1'b1);
    feed(3, 1'b0, 1'b0);
    rd(TOTAL_OFS, 34'h3);
    cfg(6'h00);
    repeat (20) @(posedge mclk);
    report_and_stop();
  end
endmodule
